// [design/swc_pkg.sv]
// Shared constants and types of the sleep and wake-up controller.
package swc_pkg;
	// Register byte offsets.
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_WDT    = 8'h08;
	// Control fields.
	localparam int CTRL_WDT_EN  = 0;
	localparam int CTRL_RC_OSC  = 1;
	localparam int CTRL_GIE     = 2;
	localparam int CTRL_IEN_LSB = 8;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	// Status fields.
	localparam int STAT_PD_BIT    = 3;
	localparam int STAT_TO_BIT    = 4;
	localparam int STAT_STATE_LSB = 5;
	localparam int STAT_NOP_BIT   = 7;
	// Interrupt sources; only the low eight run without phase clocks.
	localparam int NUM_IRQ = 9;
	localparam logic [8:0] WAKE_MASK = 9'h0FF;
	localparam logic [12:0] IRQ_VECTOR = 13'h0004;
	localparam logic [12:0] PC_STEP = 13'h0001;
	// Watchdog counts ticks of its own RC clock.
	localparam int WDT_W = 8;
	localparam logic [7:0] WDT_TIMEOUT = 8'hFF;
	// Oscillator start-up time, in oscillator periods.
	localparam int OSC_PERIOD_NS = 10;
	localparam int CLK_PERIOD_NS = 10;
	localparam int OST_TOSC = 1024;
	localparam int OST_CYCLES =
		(OST_TOSC * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OST_W = 11;
	typedef enum logic [1:0] {
		SWC_RUN    = 2'b00,
		SWC_SLEEP  = 2'b01,
		SWC_OST    = 2'b11,
		SWC_RESUME = 2'b10
	} swc_state_e;
	typedef struct packed {
		logic [7:0] level;
		logic [7:0] oe;
	} swc_io_s;
endpackage : swc_pkg

// [design/swc_sleep_wakeup_control.sv]
// Power-down controller: sleep entry, watchdog, wake-up and start-up delay.
//
// Operation
// - Only the sleep instruction puts the device into power-down.
// - Entry clears watchdog count, clears power-down flag, sets time-out flag.
// - Entry stops the oscillator driver and the phase clocks.
// - Pins keep their drive state throughout power-down.
// - Wake on master clear, watchdog time-out or enabled wake interrupt.
// - Master clear resets the device; other wakes resume execution.
// - A watchdog wake clears the time-out flag.
// - Power-down flag is set at power-up, cleared by an executed sleep.
// - Only the listed asynchronous peripheral interrupts can wake the device.
// - Phase-clocked peripherals cannot interrupt while asleep.
// - The sleep instruction prefetches the next program address.
// - A source wakes only if enabled, whatever the global enable.
// - After wake run the prefetched instruction, then vector if enabled.
// - Enabled pending flag before sleep makes sleep a no-operation.
// - Interrupt during or after sleep: full sleep effects, then wake.
// - Wake holds for 1024 oscillator periods except in RC mode; a master clear wake skips the delay here.
// - The watchdog runs from its own RC clock during power-down.
// - Watchdog time-out asleep wakes; awake it resets the device.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module swc_sleep_wakeup_control (
	// Clock and reset
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	// APB slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [7:0]             paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// Processor core
	input  wire logic                   sleep_instr,
	input  wire logic                   watchdog_kick_instr,
	input  wire logic [12:0]            program_counter,
	input  wire swc_pkg::swc_io_s       core_io,
	output logic                        core_reset_n,
	output logic                        osc_run,
	output logic                        phase_clk_run,
	output logic [12:0]                 prefetch_addr,
	output logic                        prefetch_valid,
	output logic                        resume_pulse,
	output logic                        vector_req,
	output logic [12:0]                 branch_addr,
	output logic                        sleep_as_nop,
	output logic                        powerdown_flag_n,
	output logic                        watchdog_expiry_flag_n,
	output logic                        global_irq_enable,
	// Wake sources and pins
	input  wire logic [8:0]             irq_flags,
	input  wire logic                   master_clear_n,
	input  wire logic                   wdt_rc_clk,
	output swc_pkg::swc_io_s            pin_io
);
	function automatic logic irq_hit(input logic [8:0] f,
		input logic [8:0] en, input logic [8:0] m);
		irq_hit = |(f & en & m);
	endfunction : irq_hit

	function automatic logic [12:0] pc_next(input logic [12:0] pc);
		pc_next = pc + swc_pkg::PC_STEP;
	endfunction : pc_next

	// Pin synchronisers.
	logic master_clear_n_s1, master_clear_n_s2;
	logic rc_s1, rc_s2, rc_s3;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			master_clear_n_s1 <= 1'b1;
			master_clear_n_s2 <= 1'b1;
			rc_s1   <= 1'b0;
			rc_s2   <= 1'b0;
			rc_s3   <= 1'b0;
		end else begin
			master_clear_n_s1 <= master_clear_n;
			master_clear_n_s2 <= master_clear_n_s1;
			rc_s1   <= wdt_rc_clk;
			rc_s2   <= rc_s1;
			rc_s3   <= rc_s2;
		end
	end

	logic master_clear_n_ok;
	logic wdt_tick;
	assign master_clear_n_ok = master_clear_n_s2;
	assign wdt_tick = rc_s2 & ~rc_s3;

	// Control register and its fields.
	logic [31:0] ctrl;
	logic        wdt_en, rc_mode;
	logic [8:0]  irq_en;
	assign wdt_en  = ctrl[swc_pkg::CTRL_WDT_EN];
	assign rc_mode = ctrl[swc_pkg::CTRL_RC_OSC];
	assign irq_en  = ctrl[swc_pkg::CTRL_IEN_LSB +: swc_pkg::NUM_IRQ];

	// Main state.
	swc_pkg::swc_state_e state, next_state;
	logic [swc_pkg::WDT_W-1:0] wdt_count, next_wdt_count;
	logic [swc_pkg::OST_W-1:0] ost_cnt, next_ost_cnt;
	logic next_pd_n, next_to_n, next_core_reset_n;
	logic next_osc_run, next_phase_run;
	logic [12:0] next_prefetch_addr, next_branch_addr;
	logic next_prefetch_valid, next_resume, next_vector, next_nop;
	swc_pkg::swc_io_s next_pin_io;
	logic pend_run, wake_irq, wdt_expire, enter_sleep;

	// Flags gated with enables combinationally, so no phase clock is needed.
	assign pend_run = irq_hit(irq_flags, irq_en, {swc_pkg::NUM_IRQ{1'b1}});
	assign wake_irq = irq_hit(irq_flags, irq_en, swc_pkg::WAKE_MASK);
	assign wdt_expire = wdt_en && wdt_tick && (wdt_count == swc_pkg::WDT_TIMEOUT);
	assign enter_sleep = master_clear_n_ok && state == swc_pkg::SWC_RUN &&
		sleep_instr && !pend_run;

	always_comb begin
		next_state          = state;
		next_wdt_count      = wdt_count;
		next_ost_cnt        = ost_cnt;
		next_pd_n           = powerdown_flag_n;
		next_to_n           = watchdog_expiry_flag_n;
		next_core_reset_n   = 1'b1;
		next_prefetch_addr  = prefetch_addr;
		next_prefetch_valid = prefetch_valid;
		next_branch_addr    = branch_addr;
		next_resume         = 1'b0;
		next_vector         = 1'b0;
		next_nop            = 1'b0;
		if (wdt_en && wdt_tick)
			next_wdt_count = wdt_count + 1'b1;
		if (watchdog_kick_instr)
			next_wdt_count = '0;
		if (wdt_expire)
			next_to_n = 1'b0;
		if (!master_clear_n_ok) begin
			// Master clear always wins and restarts the core from reset.
			next_state          = swc_pkg::SWC_RUN;
			next_core_reset_n   = 1'b0;
			next_wdt_count      = '0;
			next_prefetch_valid = 1'b0;
		end else begin
			case (state)
				swc_pkg::SWC_RUN: begin
					if (wdt_expire)
						next_core_reset_n = 1'b0;
					if (sleep_instr && pend_run) begin
						next_nop = 1'b1;
					end else if (sleep_instr) begin
						next_state          = swc_pkg::SWC_SLEEP;
						next_wdt_count      = '0;
						next_pd_n           = 1'b0;
						next_to_n           = 1'b1;
						next_prefetch_addr  = pc_next(program_counter);
						next_prefetch_valid = 1'b1;
					end
				end
				swc_pkg::SWC_SLEEP: begin
					// An interrupt raised in the entry cycle is seen here.
					if (wake_irq || wdt_expire) begin
						if (rc_mode)
							next_state = swc_pkg::SWC_RESUME;
						else begin
							next_state   = swc_pkg::SWC_OST;
							next_ost_cnt = swc_pkg::OST_W'(swc_pkg::OST_CYCLES - 1);
						end
					end
				end
				swc_pkg::SWC_OST: begin
					if (ost_cnt == '0)
						next_state = swc_pkg::SWC_RESUME;
					else
						next_ost_cnt = ost_cnt - 1'b1;
				end
				swc_pkg::SWC_RESUME: begin
					next_state          = swc_pkg::SWC_RUN;
					next_resume         = 1'b1;
					next_vector         = global_irq_enable;
					next_branch_addr    = swc_pkg::IRQ_VECTOR;
					next_prefetch_valid = 1'b0;
				end
				default: next_state = swc_pkg::SWC_RUN;
			endcase
		end
		if (enter_sleep)
			next_wdt_count = '0;
		next_osc_run   = next_state != swc_pkg::SWC_SLEEP;
		next_phase_run = next_state == swc_pkg::SWC_RUN;
		// Pins follow the core only while it runs; otherwise they are frozen.
		next_pin_io = (next_state == swc_pkg::SWC_RUN) ? core_io : pin_io;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state                  <= swc_pkg::SWC_RUN;
			wdt_count              <= '0;
			ost_cnt                <= '0;
			powerdown_flag_n       <= 1'b1;
			watchdog_expiry_flag_n <= 1'b1;
			core_reset_n           <= 1'b0;
			osc_run                <= 1'b1;
			phase_clk_run          <= 1'b1;
			prefetch_addr          <= '0;
			prefetch_valid         <= 1'b0;
			branch_addr            <= '0;
			resume_pulse           <= 1'b0;
			vector_req             <= 1'b0;
			sleep_as_nop           <= 1'b0;
			pin_io                 <= '0;
		end else begin
			state                  <= next_state;
			wdt_count              <= next_wdt_count;
			ost_cnt                <= next_ost_cnt;
			powerdown_flag_n       <= next_pd_n;
			watchdog_expiry_flag_n <= next_to_n;
			core_reset_n           <= next_core_reset_n;
			osc_run                <= next_osc_run;
			phase_clk_run          <= next_phase_run;
			prefetch_addr          <= next_prefetch_addr;
			prefetch_valid         <= next_prefetch_valid;
			branch_addr            <= next_branch_addr;
			resume_pulse           <= next_resume;
			vector_req             <= next_vector;
			sleep_as_nop           <= next_nop;
			pin_io                 <= next_pin_io;
		end
	end

	// APB slave: one wait state, then pready with registered data.
	logic [31:0] next_ctrl, next_prdata;
	logic        next_pready, next_pslverr, next_gie, acc, mapped;
	assign acc = psel && penable && !pready;
	assign mapped = paddr == swc_pkg::ADDR_CTRL ||
		paddr == swc_pkg::ADDR_STATUS || paddr == swc_pkg::ADDR_WDT;

	always_comb begin
		next_ctrl    = ctrl;
		next_pready  = acc;
		next_pslverr = acc && !mapped;
		next_prdata  = '0;
		if (acc && !pwrite) begin
			case (paddr)
				swc_pkg::ADDR_CTRL:   next_prdata = ctrl;
				swc_pkg::ADDR_STATUS: begin
					next_prdata[swc_pkg::STAT_PD_BIT] = powerdown_flag_n;
					next_prdata[swc_pkg::STAT_TO_BIT] = watchdog_expiry_flag_n;
					next_prdata[swc_pkg::STAT_STATE_LSB +: 2] = state;
					next_prdata[swc_pkg::STAT_NOP_BIT] = sleep_as_nop;
				end
				swc_pkg::ADDR_WDT: next_prdata[swc_pkg::WDT_W-1:0] = wdt_count;
				default: next_prdata = '0;
			endcase
		end
		// Writes land at the edge where pready is sampled high.
		if (psel && penable && pready && pwrite && paddr == swc_pkg::ADDR_CTRL)
			next_ctrl = pwdata;
		next_gie = next_ctrl[swc_pkg::CTRL_GIE];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl              <= swc_pkg::CTRL_RESET;
			prdata            <= '0;
			pready            <= 1'b0;
			pslverr           <= 1'b0;
			global_irq_enable <= 1'b0;
		end else begin
			ctrl              <= next_ctrl;
			prdata            <= next_prdata;
			pready            <= next_pready;
			pslverr           <= next_pslverr;
			global_irq_enable <= next_gie;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_sleep_only_instr: assert property (
		state != swc_pkg::SWC_SLEEP ##1 state == swc_pkg::SWC_SLEEP
		|-> $past(sleep_instr) && $past(state) == swc_pkg::SWC_RUN)
		else $error("Power-down entered without a sleep instruction.");
	a_entry_flags: assert property (
		enter_sleep |=> !powerdown_flag_n && watchdog_expiry_flag_n
		&& wdt_count == '0 && state == swc_pkg::SWC_SLEEP)
		else $error("Sleep entry effects missing.");
	a_osc_stopped: assert property (
		state == swc_pkg::SWC_SLEEP |-> !osc_run && !phase_clk_run)
		else $error("Clocks run during power-down.");
	a_pins_frozen: assert property (
		state != swc_pkg::SWC_RUN && $past(state) != swc_pkg::SWC_RUN
		|-> $stable(pin_io))
		else $error("Pin drive changed while asleep.");
	a_irq_wake: assert property (
		state == swc_pkg::SWC_SLEEP && master_clear_n_ok && wake_irq
		|=> state != swc_pkg::SWC_SLEEP && core_reset_n)
		else $error("Enabled interrupt did not wake.");
	a_master_clear_n_reset: assert property (
		!master_clear_n_ok |=> !core_reset_n && state == swc_pkg::SWC_RUN)
		else $error("Master clear did not reset.");
	a_wdt_wake: assert property (
		state == swc_pkg::SWC_SLEEP && master_clear_n_ok && wdt_expire
		|=> !watchdog_expiry_flag_n && core_reset_n
		&& state != swc_pkg::SWC_SLEEP)
		else $error("Watchdog wake wrong.");
	a_nop_sleep: assert property (
		state == swc_pkg::SWC_RUN && master_clear_n_ok && sleep_instr && pend_run
		|=> state == swc_pkg::SWC_RUN && sleep_as_nop
		&& powerdown_flag_n == $past(powerdown_flag_n))
		else $error("Sleep with pending interrupt was not a no-op.");
	a_prefetch_addr: assert property (
		enter_sleep |=> prefetch_valid
		&& prefetch_addr == 13'($past(program_counter) + swc_pkg::PC_STEP))
		else $error("Prefetch address wrong.");
	a_ost_delay: assert property (
		state == swc_pkg::SWC_SLEEP ##1 state == swc_pkg::SWC_OST
		|-> ost_cnt == swc_pkg::OST_W'(swc_pkg::OST_CYCLES - 1))
		else $error("Start-up delay not loaded with 1024 cycles.");
	a_ost_end: assert property (
		state == swc_pkg::SWC_OST && ost_cnt == '0 && master_clear_n_ok
		|=> state == swc_pkg::SWC_RESUME ##1 resume_pulse)
		else $error("Start-up delay end wrong.");
	a_resume_vector: assert property (
		state == swc_pkg::SWC_RESUME && master_clear_n_ok
		|=> resume_pulse && vector_req == $past(global_irq_enable))
		else $error("Resume vector choice wrong.");
	a_timer_no_wake: assert property (
		state == swc_pkg::SWC_SLEEP && master_clear_n_ok && !wake_irq && !wdt_expire |=> state == swc_pkg::SWC_SLEEP)
		else $error("Woke without an eligible wake source.");
	a_wdt_reset_awake: assert property (
		state == swc_pkg::SWC_RUN && master_clear_n_ok && wdt_expire && !sleep_instr |=> !core_reset_n)
		else $error("Watchdog time-out while running did not reset the core.");

	c_nop_sleep: cover property (sleep_as_nop);
	c_irq_wake: cover property (state == swc_pkg::SWC_SLEEP && wake_irq);
	c_wdt_wake: cover property (state == swc_pkg::SWC_SLEEP && wdt_expire);
	c_master_clear_n_sleep: cover property (state == swc_pkg::SWC_SLEEP && !master_clear_n_ok);
	c_ost_done: cover property (state == swc_pkg::SWC_OST ##1 state == swc_pkg::SWC_RESUME);
endmodule : swc_sleep_wakeup_control

// [test/swc_wake_model.sv]
// Wake-source model: interrupt flag sources and the watchdog RC clock.
`timescale 1ns/1ps
module swc_wake_model (
	// Clock
	input  wire logic       pclk,
	// Requests from the bench
	input  wire logic [8:0] raise,
	// Wake sources
	output logic      [8:0] irq_flags,
	output logic            wdt_rc_clk
);
	initial begin
		wdt_rc_clk = 1'b0;
		irq_flags = 9'h000;
	end
	// The RC clock runs free; its edges never land on a rising pclk edge.
	always #36 wdt_rc_clk = ~wdt_rc_clk;
	// Flags are levels held until the bench withdraws them.
	always @(posedge pclk) irq_flags <= raise;
endmodule : swc_wake_model

// [test/tb.sv]
// Self-checking bench of the sleep and wake-up controller.
`timescale 1ns/1ps
module tb;
	logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]       paddr;
	logic [31:0]      pwdata, prdata, rd;
	logic             sleep_instr, watchdog_kick_instr, core_reset_n, osc_run, phase_clk_run;
	logic             prefetch_valid, resume_pulse, vector_req, sleep_as_nop, global_irq_enable;
	logic             powerdown_flag_n, watchdog_expiry_flag_n, master_clear_n, wdt_rc_clk;
	logic [12:0]      program_counter, prefetch_addr, branch_addr;
	logic [8:0]       raise, irq_flags;
	swc_pkg::swc_io_s core_io, pin_io;
	int               num_errors, compares, n;

	swc_sleep_wakeup_control swc_sleep_wakeup_control_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sleep_instr(sleep_instr), .watchdog_kick_instr(watchdog_kick_instr),
		.program_counter(program_counter), .core_io(core_io), .core_reset_n(core_reset_n),
		.osc_run(osc_run), .phase_clk_run(phase_clk_run), .prefetch_addr(prefetch_addr),
		.prefetch_valid(prefetch_valid), .resume_pulse(resume_pulse), .vector_req(vector_req),
		.branch_addr(branch_addr), .sleep_as_nop(sleep_as_nop), .powerdown_flag_n(powerdown_flag_n),
		.watchdog_expiry_flag_n(watchdog_expiry_flag_n), .global_irq_enable(global_irq_enable),
		.irq_flags(irq_flags), .master_clear_n(master_clear_n), .wdt_rc_clk(wdt_rc_clk), .pin_io(pin_io));

	swc_wake_model swc_wake_model_inst (.pclk(pclk), .raise(raise), .irq_flags(irq_flags), .wdt_rc_clk(wdt_rc_clk));

	task automatic summarize;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic cyc(input int k);
		repeat (k) @(posedge pclk);
	endtask : cyc

	// Bus cycle; the answer time is never assumed, only bounded.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			num_errors++;
			summarize();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// The kick ahead of the sleep keeps the watchdog clear even if the sleep is skipped.
	task automatic do_sleep(input logic [12:0] a);
		@(posedge pclk);
		watchdog_kick_instr <= 1'b1;
		@(posedge pclk);
		watchdog_kick_instr <= 1'b0;
		sleep_instr <= 1'b1;
		program_counter <= a;
		@(posedge pclk);
		sleep_instr <= 1'b0;
		@(negedge pclk);
	endtask : do_sleep

	task automatic wait_resume(input int lim);
		n = 0;
		while (resume_pulse !== 1'b1) begin
			@(negedge pclk);
			n++;
			if (n > lim) begin
				num_errors++;
				summarize();
			end
		end
	endtask : wait_resume

	task automatic t_regs;
		chk(powerdown_flag_n, 1);
		apb(1'b0, swc_pkg::ADDR_CTRL, 32'h0);
		chk(rd, swc_pkg::CTRL_RESET);
		apb(1'b0, 8'h0C, 32'h0);
		chk(err, 1);
		chk(rd, 0);
	endtask : t_regs

	task automatic t_nop;
		apb(1'b1, swc_pkg::ADDR_CTRL, 32'h0000_0204);
		raise <= 9'h002;
		cyc(2);
		do_sleep(13'h0040);
		chk(sleep_as_nop, 1);
		chk(powerdown_flag_n, 1);
		chk(watchdog_expiry_flag_n, 1);
		chk(phase_clk_run, 1);
		@(posedge pclk);
		raise <= 9'h000;
	endtask : t_nop

	task automatic t_irq;
		apb(1'b1, swc_pkg::ADDR_CTRL, 32'h0000_0104);
		@(negedge pclk);
		chk(global_irq_enable, 1);
		core_io <= 16'h5AA5;
		cyc(3);
		do_sleep(13'h0100);
		chk(osc_run, 0);
		chk(phase_clk_run, 0);
		chk(powerdown_flag_n, 0);
		chk(watchdog_expiry_flag_n, 1);
		chk(prefetch_addr, 13'h0101);
		chk(prefetch_valid, 1);
		@(posedge pclk);
		core_io <= 16'h00FF;
		raise <= 9'h002;
		cyc(20);
		@(negedge pclk);
		chk(osc_run, 0);
		chk(pin_io, 16'h5AA5);
		@(posedge pclk);
		raise <= 9'h001;
		wait_resume(1100);
		chk(n >= swc_pkg::OST_CYCLES, 1);
		chk(n <= swc_pkg::OST_CYCLES + 8, 1);
		chk(vector_req, 1);
		chk(branch_addr, swc_pkg::IRQ_VECTOR);
		chk(core_reset_n, 1);
		chk(phase_clk_run, 1);
		chk(watchdog_expiry_flag_n, 1);
		@(posedge pclk);
		raise <= 9'h000;
		apb(1'b0, swc_pkg::ADDR_STATUS, 32'h0);
		chk(rd, 32'h1 << swc_pkg::STAT_TO_BIT);
		apb(1'b0, swc_pkg::ADDR_WDT, 32'h0);
		chk(rd, 0);
	endtask : t_irq

	// Every wake-capable source in turn, in RC mode so no start-up delay applies.
	task automatic t_sources;
		apb(1'b1, swc_pkg::ADDR_CTRL, 32'h0001_FF02);
		for (int i = 0; i < 8; i++) begin
			do_sleep(13'h0200);
			@(posedge pclk);
			raise <= 9'h100;
			cyc(20);
			@(negedge pclk);
			chk(osc_run, 0);
			@(posedge pclk);
			raise <= 9'h100 | (9'h001 << i);
			wait_resume(10);
			chk(vector_req, 0);
			@(posedge pclk);
			raise <= 9'h000;
		end
	endtask : t_sources

	task automatic t_wdt;
		apb(1'b1, swc_pkg::ADDR_CTRL, 32'h0000_0003);
		do_sleep(13'h0300);
		wait_resume(4000);
		chk(watchdog_expiry_flag_n, 0);
		chk(core_reset_n, 1);
		// Left enabled while awake, the next time-out must reset the core for one cycle.
		n = 0;
		while (core_reset_n !== 1'b0) begin
			@(negedge pclk);
			n++;
			if (n > 4000) begin
				num_errors++;
				summarize();
			end
		end
		chk(core_reset_n, 0);
		chk(phase_clk_run, 1);
		@(negedge pclk);
		chk(core_reset_n, 1);
		apb(1'b1, swc_pkg::ADDR_CTRL, 32'h0);
	endtask : t_wdt

	task automatic t_master_clear_n;
		do_sleep(13'h0400);
		@(posedge pclk);
		master_clear_n <= 1'b0;
		cyc(4);
		@(negedge pclk);
		chk(core_reset_n, 0);
		chk(osc_run, 1);
		@(posedge pclk);
		master_clear_n <= 1'b1;
		cyc(4);
		@(negedge pclk);
		chk(core_reset_n, 1);
		chk(prefetch_valid, 0);
	endtask : t_master_clear_n

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		sleep_instr = 1'b0;
		watchdog_kick_instr = 1'b0;
		program_counter = 13'h0000;
		core_io = 16'h0000;
		master_clear_n = 1'b1;
		raise = 9'h000;
		num_errors = 0;
		compares = 0;
		cyc(4);
		presetn <= 1'b1;
		cyc(2);
		@(negedge pclk);
		t_regs();
		t_nop();
		t_irq();
		t_sources();
		t_wdt();
		t_master_clear_n();
		summarize();
	end
endmodule : tb
